// *** hw/lpmc_pkg.sv ***
// package for the low-power mode controller: register map, fields, reset values, counts
// assumes an APB slave with 32-bit data and one aligned word per register
//
// What this block does
// - mode field 00 is idle, 01 standby, 1x halt
// - idle makes no clock change; any enabled interrupt ends it
// - idle ends on external reset, watchdog interrupt or enabled interrupt
// - standby keeps oscillator running, stops cpu input and system clocks
// - standby ends on external reset, watchdog interrupt, selected pin or debugger
// - only port A pins enabled in wake pin select may wake
// - selected pin wakes are qualified for a programmed oscillator cycle count
// - halt stops crystal, pll and clocks; internal oscillator and watchdog per software
// - halt ends on watchdog, external reset, debugger or selected pin
// - wake signals are active low; too short a pulse keeps the mode, but any low external reset wakes
// - low-power modes leave all output pins unchanged
// - test access port keeps working while cpu clock is stopped
// - halt is entered only while the watchdog clock is active
// - active-low watchdog interrupt can wake the device from standby
// - in halt the watchdog wakes the device by a device reset
`default_nettype none
package lpmc_pkg;
  // register byte offsets
  localparam logic [7:0] LPMC_CTRL_OFF = 8'h00;   // low_power_control
  localparam logic [7:0] LPMC_WSEL_OFF = 8'h04;   // wake_pin_select
  localparam logic [7:0] LPMC_STAT_OFF = 8'h08;   // status, read only
  // low_power_control fields
  localparam int LPMC_MODE_LSB = 0;
  localparam int LPMC_QUAL_LSB = 2;
  localparam int LPMC_QUAL_W = 6;
  localparam int LPMC_WDEN_BIT = 8;   // watchdog interrupt wakes standby
  localparam int LPMC_INTOSC_BIT = 9; // internal oscillator kept in halt
  localparam int LPMC_WDHALT_BIT = 10; // watchdog kept running in halt
  localparam logic [31:0] LPMC_CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] LPMC_WSEL_RST = 32'h0000_0000;
  // qualification count is field value plus this many oscillator cycles
  localparam logic [6:0] LPMC_QUAL_BASE = 7'h02;
  // low time that must be exceeded to count as a recognised interrupt, in oscillator cycles
  localparam logic [2:0] LPMC_WAKE_MIN_CYC = 3'h3;

  typedef enum logic [3:0] {
    LPMC_ST_RUN = 4'h1,
    LPMC_ST_IDLE = 4'h2,
    LPMC_ST_STBY = 4'h4,
    LPMC_ST_HALT = 4'h8
  } lpmc_state_t;

  // clock gating outputs travel together
  typedef struct packed {
    logic cpu_input_clock_en;
    logic system_clock_out_en;
    logic xtal_pll_en;
    logic intosc_en;
    logic watchdog_en;
  } lpmc_clk_t;
  localparam lpmc_clk_t LPMC_CLK_ALL_ON = 5'h1F;
endpackage : lpmc_pkg
`default_nettype wire

// *** hw/lpmc_lowfilt.sv ***
// low-level filter: flags an active-low input that stayed low long enough
// assumes the input is synchronous to pclk
`default_nettype none
module lpmc_lowfilt #(
  parameter int CNT_W = 7
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // filter
  input wire logic in_n,
  input wire logic [CNT_W-1:0] need,
  output logic hit
);
  logic [CNT_W-1:0] cnt_reg;

  // count consecutive low cycles; any high drops the count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= '0;
    end else if (in_n) begin
      cnt_reg <= '0;
    end else if (cnt_reg != need) begin
      cnt_reg <= cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  // hit holds while low and the count is reached
  assign hit = !in_n && (cnt_reg == need);
endmodule : lpmc_lowfilt
`default_nettype wire

// *** hw/lpmc_top.sv ***
// low-power mode controller: apb registers, mode state machine, clock gating
// assumes pclk is the oscillator clock and wake inputs are synchronous to it
`default_nettype none
module lpmc_top #(
  parameter int PINS = 32
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // core and wake sources
  input wire logic idle_exec,
  input wire logic external_reset_n,
  input wire logic watchdog_wake_int_n,
  input wire logic watchdog_clock_active,
  input wire logic debug_wake_n,
  input wire logic int_pending_n,
  input wire logic [PINS-1:0] port_a_n,
  // clock control and status to the system
  output lpmc_pkg::lpmc_clk_t clk_ctrl,
  output logic wake_done,
  output logic halt_wd_reset_req,
  output logic halt_refused
);
  lpmc_pkg::lpmc_state_t state_reg, state_next;
  logic [31:0] ctrl_reg;
  logic [PINS-1:0] wsel_reg;
  logic [31:0] rdata_next;
  logic pin_low_n, pin_hit, wd_hit, dbg_hit, int_hit;
  logic wake_idle, wake_stby, wake_halt;
  logic [6:0] qual_need;
  logic [1:0] mode;
  logic apb_wr, apb_rd;

  // one-cycle access phase; pready is high only in the cycle after setup
  assign apb_wr = psel && penable && pwrite;
  assign apb_rd = psel && !penable && !pwrite;

  // byte-lane write of a 32-bit word
  function automatic logic [31:0] lpmc_merge(input logic [31:0] old,
                                              input logic [31:0] nw,
                                              input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction : lpmc_merge

  // control register writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= lpmc_pkg::LPMC_CTRL_RST;
    end else if (apb_wr && paddr == lpmc_pkg::LPMC_CTRL_OFF) begin
      ctrl_reg <= lpmc_merge(ctrl_reg, pwdata, pstrb) & 32'h0000_07FF;
    end
  end

  // wake pin select register writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wsel_reg <= lpmc_pkg::LPMC_WSEL_RST[PINS-1:0];
    end else if (apb_wr && paddr == lpmc_pkg::LPMC_WSEL_OFF) begin
      wsel_reg <= lpmc_merge({{(32-PINS){1'b0}}, wsel_reg}, pwdata, pstrb)
                  [PINS-1:0];
    end
  end

  // read mux; unmapped offsets read zero
  always_comb begin
    rdata_next = 32'h0000_0000;
    case (paddr)
      lpmc_pkg::LPMC_CTRL_OFF: rdata_next = ctrl_reg;
      lpmc_pkg::LPMC_WSEL_OFF: rdata_next = {{(32-PINS){1'b0}}, wsel_reg};
      lpmc_pkg::LPMC_STAT_OFF: rdata_next = {27'h0, state_reg, halt_refused};
      default: rdata_next = 32'h0000_0000;
    endcase
  end

  // read data captured in setup so it comes straight from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (apb_rd) begin
      prdata <= rdata_next;
    end
  end

  // pslverr flags unmapped offsets during access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && paddr != lpmc_pkg::LPMC_CTRL_OFF &&
                 paddr != lpmc_pkg::LPMC_WSEL_OFF && paddr != lpmc_pkg::LPMC_STAT_OFF;
    end
  end

  assign mode = ctrl_reg[lpmc_pkg::LPMC_MODE_LSB +: 2];

  // only selected pins are seen, active low
  assign pin_low_n = ~|(~port_a_n & wsel_reg);

  assign qual_need = {1'b0, ctrl_reg[lpmc_pkg::LPMC_QUAL_LSB +: lpmc_pkg::LPMC_QUAL_W]} +
                     lpmc_pkg::LPMC_QUAL_BASE;

  // pin wake qualified on oscillator cycles
  lpmc_lowfilt #(.CNT_W(7)) u_pin_filt (
    .pclk(pclk),
    .presetn(presetn),
    .in_n(pin_low_n),
    .need(qual_need),
    .hit(pin_hit)
  );

  // short pulses on watchdog, debug and interrupt sources are ignored
  lpmc_lowfilt #(.CNT_W(3)) u_wd_filt (
    .pclk(pclk),
    .presetn(presetn),
    .in_n(watchdog_wake_int_n),
    .need(lpmc_pkg::LPMC_WAKE_MIN_CYC),
    .hit(wd_hit)
  );
  lpmc_lowfilt #(.CNT_W(3)) u_dbg_filt (
    .pclk(pclk),
    .presetn(presetn),
    .in_n(debug_wake_n),
    .need(lpmc_pkg::LPMC_WAKE_MIN_CYC),
    .hit(dbg_hit)
  );
  lpmc_lowfilt #(.CNT_W(3)) u_int_filt (
    .pclk(pclk),
    .presetn(presetn),
    .in_n(int_pending_n),
    .need(lpmc_pkg::LPMC_WAKE_MIN_CYC),
    .hit(int_hit)
  );

  assign wake_idle = !external_reset_n || wd_hit || int_hit;
  // standby exits; watchdog only when enabled
  // debugger request path uses pclk, not the stopped cpu clock
  assign wake_stby = !external_reset_n || pin_hit || dbg_hit ||
                     (wd_hit && ctrl_reg[lpmc_pkg::LPMC_WDEN_BIT]);
  assign wake_halt = !external_reset_n || pin_hit || dbg_hit || wd_hit;

  // mode state machine
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      lpmc_pkg::LPMC_ST_RUN: begin
        // idle instruction enters the selected mode
        if (idle_exec) begin
          if (mode == 2'b00) begin
            state_next = lpmc_pkg::LPMC_ST_IDLE;
          end else if (mode == 2'b01) begin
            state_next = lpmc_pkg::LPMC_ST_STBY;
          // halt needs a live watchdog clock
          end else if (watchdog_clock_active) begin
            state_next = lpmc_pkg::LPMC_ST_HALT;
          end
        end
      end
      lpmc_pkg::LPMC_ST_IDLE: if (wake_idle) state_next = lpmc_pkg::LPMC_ST_RUN;
      lpmc_pkg::LPMC_ST_STBY: if (wake_stby) state_next = lpmc_pkg::LPMC_ST_RUN;
      lpmc_pkg::LPMC_ST_HALT: if (wake_halt) state_next = lpmc_pkg::LPMC_ST_RUN;
      default: state_next = lpmc_pkg::LPMC_ST_RUN;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= lpmc_pkg::LPMC_ST_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  // clock gating per next state, registered
  // no output pin is touched here; only clock enables change
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_ctrl <= lpmc_pkg::LPMC_CLK_ALL_ON;
    end else begin
      clk_ctrl <= lpmc_pkg::LPMC_CLK_ALL_ON;
      case (state_next)
        lpmc_pkg::LPMC_ST_IDLE: clk_ctrl <= lpmc_pkg::LPMC_CLK_ALL_ON;
        lpmc_pkg::LPMC_ST_STBY: begin
          clk_ctrl.cpu_input_clock_en <= 1'b0;
          clk_ctrl.system_clock_out_en <= 1'b0;
        end
        // halt: cpu, system, crystal and pll clocks off; internal oscillator and watchdog per software
        lpmc_pkg::LPMC_ST_HALT: begin
          clk_ctrl.cpu_input_clock_en <= 1'b0;
          clk_ctrl.system_clock_out_en <= 1'b0;
          clk_ctrl.xtal_pll_en <= 1'b0;
          clk_ctrl.intosc_en <= ctrl_reg[lpmc_pkg::LPMC_INTOSC_BIT];
          clk_ctrl.watchdog_en <= ctrl_reg[lpmc_pkg::LPMC_WDHALT_BIT];
        end
        default: clk_ctrl <= lpmc_pkg::LPMC_CLK_ALL_ON;
      endcase
    end
  end

  // wake pulse, halt watchdog reset, refused halt flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_done <= 1'b0;
      halt_wd_reset_req <= 1'b0;
      halt_refused <= 1'b0;
    end else begin
      wake_done <= state_reg != lpmc_pkg::LPMC_ST_RUN &&
                   state_next == lpmc_pkg::LPMC_ST_RUN;
      // watchdog wake from halt is a device reset
      halt_wd_reset_req <= state_reg == lpmc_pkg::LPMC_ST_HALT && wd_hit;
      // record a halt request that was refused; cleared by next idle
      if (state_reg == lpmc_pkg::LPMC_ST_RUN && idle_exec) begin
        halt_refused <= mode[1] && !watchdog_clock_active;
      end
    end
  end
endmodule : lpmc_top
`default_nettype wire

// *** test/lpmc_assertions.sv ***
// checker for the low-power mode controller, bound to its top ports
// assumes one clock domain, pclk, with async active-low presetn
`default_nettype none
module lpmc_assertions (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb handshake
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  // core, wake and clock control
  input wire logic idle_exec,
  input wire logic external_reset_n,
  input wire logic watchdog_clock_active,
  input wire lpmc_pkg::lpmc_clk_t clk_ctrl,
  input wire logic wake_done,
  input wire logic halt_refused
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_wake_flag;
    ##[0:1] wake_done;
  endsequence
  // apb slave answers one cycle after setup
  a_apb_answer: assert property (s_setup |=> pready)
    else $error("pready missing after setup");
  a_stop_pair: assert property (clk_ctrl.cpu_input_clock_en == clk_ctrl.system_clock_out_en)
    else $error("cpu and system clocks differ");
  a_xtal_halt: assert property (!clk_ctrl.xtal_pll_en |-> !clk_ctrl.cpu_input_clock_en)
    else $error("crystal off while cpu clock on");
  a_halt_watchdog_clock: assert property ($fell(clk_ctrl.xtal_pll_en) |-> $past(watchdog_clock_active))
    else $error("halt entered without watchdog clock");
  a_entry_cause: assert property ($fell(clk_ctrl.cpu_input_clock_en) |->
    $past(idle_exec) || $past(idle_exec, 2))
    else $error("clocks stopped without idle");
  a_refused_run: assert property ($rose(halt_refused) |-> clk_ctrl == 5'h1F)
    else $error("refused halt stopped clocks");
  a_ext_wake: assert property (!external_reset_n |=> clk_ctrl.cpu_input_clock_en)
    else $error("external reset did not wake");
  a_wake_flag: assert property ($rose(clk_ctrl.cpu_input_clock_en) |-> s_wake_flag)
    else $error("wake_done missing");
endmodule : lpmc_assertions
bind lpmc_top lpmc_assertions chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pready(pready), .idle_exec(idle_exec),
  .external_reset_n(external_reset_n), .watchdog_clock_active(watchdog_clock_active),
  .clk_ctrl(clk_ctrl), .wake_done(wake_done), .halt_refused(halt_refused));
`default_nettype wire

// *** test/lpmc_core_model.sv ***
// model of the core and the wake pins beside the controller
// assumes wake lines idle high, as with pull-ups
`default_nettype none
module lpmc_core_model (
  // clock
  input wire logic pclk,
  // core strobe and wake lines: 31:0 pins, 32 watchdog, 33 debug, 34 int, 35 ext
  output logic idle_exec,
  output logic [35:0] wake_n
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    idle_exec = 1'b0;
    wake_n = '1;
  end
  task idle();
    @(posedge pclk);
    idle_exec <= 1'b1;
    @(posedge pclk);
    idle_exec <= 1'b0;
  endtask : idle
  // active-low wake level, held n cycles
  task low(input int s, input int n);
    @(posedge pclk);
    wake_n[s] <= 1'b0;
    repeat (n) @(posedge pclk);
    wake_n[s] <= 1'b1;
  endtask : low
endmodule : lpmc_core_model
`default_nettype wire

// *** test/tb.sv ***
// testbench: apb register checks and walks through idle, standby and halt
// assumes the core model drives idle and wake lines
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, wdca = 1, rq = 0, e;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, idle_exec, wake_done, halt_wd_reset_req, halt_refused;
  logic [35:0] w_n;
  lpmc_pkg::lpmc_clk_t clk_ctrl;
  int fails = 0, cmp_count = 0, wakes = 0;
  int idw[3] = '{34, 32, 35};
  int sbw[3] = '{32, 33, 35};
  always #4 pclk = ~pclk;
  // sticky, the request is a short pulse
  always @(posedge pclk) if (halt_wd_reset_req === 1'b1) rq <= 1'b1;
  // count wake pulses, one per return to run
  always @(posedge pclk) if (wake_done === 1'b1) wakes <= wakes + 1;
  lpmc_core_model core_u (.pclk(pclk), .idle_exec(idle_exec), .wake_n(w_n));
  lpmc_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .idle_exec(idle_exec),
    .external_reset_n(w_n[35]), .watchdog_wake_int_n(w_n[32]),
    .watchdog_clock_active(wdca), .debug_wake_n(w_n[33]), .int_pending_n(w_n[34]),
    .port_a_n(w_n[31:0]), .clk_ctrl(clk_ctrl), .wake_done(wake_done),
    .halt_wd_reset_req(halt_wd_reset_req), .halt_refused(halt_refused));
  task chk(input string nm, input logic [31:0] got, input logic [31:0] ex);
    cmp_count++;
    if (got !== ex) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", nm, ex, got);
    end
  endtask : chk
  task close_out();
    $display("compared %0d, mismatched %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : close_out
  // one apb transfer, request held until pready is sampled
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (n == 16) begin
      fails++;
      close_out();
    end
    r = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb
  task st(input logic [31:0] ex);
    apb(1'b0, lpmc_pkg::LPMC_STAT_OFF, 32'h0);
    chk("status", r, ex);
  endtask : st
  task enter(input logic [31:0] c, input logic [31:0] ex);
    apb(1'b1, lpmc_pkg::LPMC_CTRL_OFF, c);
    core_u.idle();
    repeat (3) @(posedge pclk);
    st(ex);
  endtask : enter
  // qualification length is fixed by the mode settings
  task go(input int s, input int n, input logic [31:0] ex);
    core_u.low(s, n);
    repeat (4) @(posedge pclk);
    st(ex);
  endtask : go
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, lpmc_pkg::LPMC_CTRL_OFF, 32'h0);
    chk("ctrl", r, lpmc_pkg::LPMC_CTRL_RST);
    apb(1'b0, lpmc_pkg::LPMC_WSEL_OFF, 32'h0);
    chk("wsel", r, lpmc_pkg::LPMC_WSEL_RST);
    chk("clocks", 32'(clk_ctrl), 32'h1F);
    apb(1'b1, 8'h0C, 32'hFFFF_FFFF);
    chk("slverr", 32'(e), 32'h1);
    apb(1'b0, 8'h0C, 32'h0);
    chk("unmapped", r, 32'h0);
    apb(1'b1, lpmc_pkg::LPMC_WSEL_OFF, 32'h0000_0020);
    apb(1'b0, lpmc_pkg::LPMC_WSEL_OFF, 32'h0);
    chk("wsel", r, 32'h0000_0020);
    $display("registers done");
    foreach (idw[i]) begin
      enter(32'h0, 32'h4);
      chk("idle clocks", 32'(clk_ctrl), 32'h1F);
      go(idw[i], 8, 32'h2);
    end
    $display("idle done");
    enter(32'h0000_010D, 32'h8);
    chk("stby clocks", 32'(clk_ctrl[4:2]), 32'h1);
    go(6, 8, 32'h8);
    go(5, 4, 32'h8);
    go(34, 8, 32'h8);
    go(32, 3, 32'h8);
    go(5, 8, 32'h2);
    foreach (sbw[i]) begin
      enter(32'h0000_010D, 32'h8);
      go(sbw[i], 8, 32'h2);
    end
    $display("standby done");
    wdca <= 1'b0;
    enter(32'h0000_0202, 32'h3);
    chk("refused", 32'(halt_refused), 32'h1);
    wdca <= 1'b1;
    enter(32'h0000_0202, 32'h10);
    chk("halt clocks", 32'(clk_ctrl), 32'h02);
    go(5, 8, 32'h2);
    enter(32'h0000_0603, 32'h10);
    chk("halt clocks", 32'(clk_ctrl), 32'h03);
    go(33, 8, 32'h2);
    enter(32'h0000_0603, 32'h10);
    core_u.low(32, 8);
    go(35, 8, 32'h2);
    chk("wd reset", 32'(rq), 32'h1);
    chk("wakes", 32'(wakes), 32'hA);
    $display("halt done");
    close_out();
  end
endmodule : tb
`default_nettype wire
